// File: pfrpc_pkg.sv
// Package for the synthesizer control register bank.
// Assumes a single 40 MHz clock domain and a decoded register write/read port.
package pfrpc_pkg;
  localparam int                     DATA_W          = 24;
  localparam int                     ADDR_W          = 5;
  localparam logic [ADDR_W-1:0]      ADDR_RST_ID     = 5'h00;
  localparam logic [ADDR_W-1:0]      ADDR_PWR        = 5'h01;
  localparam logic [ADDR_W-1:0]      ADDR_INTG       = 5'h03;
  localparam logic [ADDR_W-1:0]      ADDR_FRAC       = 5'h04;
  localparam logic [ADDR_W-1:0]      ADDR_VCO        = 5'h05;
  localparam logic [ADDR_W-1:0]      ADDR_MOD        = 5'h06;
  localparam logic [ADDR_W-1:0]      ADDR_STEP       = 5'h0C;
  localparam int                     SOFT_RST_BIT    = 5;
  localparam int                     PWR_PIN_EN_BIT  = 0;
  localparam int                     PWR_SW_PD_BIT   = 1;
  localparam int                     KEEP_LO_BIT     = 2;
  localparam int                     KEEP_N          = 6;
  localparam int                     SEED_LO         = 0;
  localparam int                     SEED_W          = 2;
  localparam int                     RDADDR_W        = 5;
  // Identity value is arbitrary
  localparam logic [DATA_W-1:0]      CHIP_ID         = 24'hA5A5A5;
  localparam logic [DATA_W-1:0]      PWR_RST_VAL     = 24'h000001;
  localparam logic [DATA_W-1:0]      INTG_RST_VAL    = 24'h000019;
  localparam logic [DATA_W-1:0]      FRAC_RST_VAL    = 24'h000000;
  localparam logic [DATA_W-1:0]      MOD_RST_VAL     = 24'h000002;
  localparam logic [DATA_W-1:0]      STEP_RST_VAL    = 24'h000000;
  localparam logic [DATA_W-1:0]      VCO_RST_VAL     = 24'h000000;
  localparam logic [DATA_W-1:0]      SEED0           = 24'h000000;
  localparam logic [DATA_W-1:0]      SEED1           = 24'h800000;
  localparam logic [DATA_W-1:0]      SEED2           = 24'h5A3C96;
  localparam logic [DATA_W-1:0]      SEED3           = 24'h400000;
  localparam int                     POR_US          = 250;
  localparam int                     CLK_MHZ         = 40;
  localparam int                     POR_CYCLES      = POR_US * CLK_MHZ;
  localparam int                     POR_CNT_W       = 14;
endpackage

// File: pfrpc_ctrl.sv
// Register bank: divide, fractional, seed, reset and power-down control.
// Assumes the serial framing delivers one-cycle write strobes with address and data.
// Operation
// - Channel change rewrites only fraction; integer and step registers persist.
// - Two-bit seed field picks one of four accumulator start phases.
// - Each new fraction reloads the chosen seed into the accumulator.
// - Power-on reset holds subsystem and VCO registers at defaults until about 250 us after power-up.
// - Writing register zero with bit five set resets subsystem registers.
// - Soft reset keeps the serial port mode unchanged.
// - Soft reset and enable pin never touch VCO registers.
// - With pin honoured, low enable pin stops analog and internal clocks.
// - Serial port keeps answering while powered down.
// - Clearing pin-enable bit takes power-down from register bit one.
// - Bits two to seven keep listed blocks powered during power-down.
`timescale 1ns/1ps
`default_nettype none
module pfrpc_ctrl #(
  parameter int POR_CYCLES = pfrpc_pkg::POR_CYCLES
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  input  wire logic                            wr_strobe,
  input  wire logic [pfrpc_pkg::ADDR_W-1:0]    wr_addr,
  input  wire logic [pfrpc_pkg::DATA_W-1:0]    wr_data,
  input  wire logic                            chip_enable_pin,
  input  wire logic                            spi_mode_in,
  input  wire logic                            spi_mode_load,
  output var  logic [pfrpc_pkg::DATA_W-1:0]    rd_data,
  output var  logic                            por_done,
  output var  logic                            spi_mode,
  output var  logic [pfrpc_pkg::DATA_W-1:0]    int_div,
  output var  logic [pfrpc_pkg::DATA_W-1:0]    frac_div,
  output var  logic [pfrpc_pkg::DATA_W-1:0]    step_count,
  output var  logic [pfrpc_pkg::DATA_W-1:0]    mod_cfg,
  output var  logic [pfrpc_pkg::DATA_W-1:0]    vco_access,
  output var  logic [pfrpc_pkg::DATA_W-1:0]    phase_accumulator,
  output var  logic                            powered_down,
  output var  logic                            clocks_run,
  output var  logic [pfrpc_pkg::KEEP_N-1:0]    block_on
);
  logic [pfrpc_pkg::POR_CNT_W-1:0] por_cnt_reg;
  logic                            por_done_reg;
  logic [pfrpc_pkg::DATA_W-1:0]    pwr_reg, intg_reg, frac_reg, mod_reg, step_reg, vco_reg;
  logic [pfrpc_pkg::RDADDR_W-1:0]  rdaddr_reg;
  logic                            mode_reg;
  logic [pfrpc_pkg::DATA_W-1:0]    acc_reg;
  logic                            pd_reg;
  logic [pfrpc_pkg::KEEP_N-1:0]    on_reg;
  logic [pfrpc_pkg::DATA_W-1:0]    rd_reg;
  logic                            run_reg;
  localparam int                   CNT_W = pfrpc_pkg::POR_CNT_W;

  wire por_active = !por_done_reg;
  wire wr_ok      = wr_strobe && por_done_reg;
  wire wr_r0      = wr_ok && (wr_addr == pfrpc_pkg::ADDR_RST_ID);
  wire soft_rst   = wr_r0 && wr_data[pfrpc_pkg::SOFT_RST_BIT];
  wire clr        = por_active || soft_rst;
  wire wr_pwr     = wr_ok && (wr_addr == pfrpc_pkg::ADDR_PWR);
  wire wr_intg    = wr_ok && (wr_addr == pfrpc_pkg::ADDR_INTG);
  wire wr_frac    = wr_ok && (wr_addr == pfrpc_pkg::ADDR_FRAC);
  wire wr_vco     = wr_ok && (wr_addr == pfrpc_pkg::ADDR_VCO);
  wire wr_mod     = wr_ok && (wr_addr == pfrpc_pkg::ADDR_MOD);
  wire wr_step    = wr_ok && (wr_addr == pfrpc_pkg::ADDR_STEP);
  wire [pfrpc_pkg::SEED_W-1:0] seed_sel = mod_reg[pfrpc_pkg::SEED_LO +: pfrpc_pkg::SEED_W];
  wire [pfrpc_pkg::DATA_W-1:0] seed_val =
    (seed_sel == 2'h0) ? pfrpc_pkg::SEED0 :
    (seed_sel == 2'h1) ? pfrpc_pkg::SEED1 :
    (seed_sel == 2'h2) ? pfrpc_pkg::SEED2 : pfrpc_pkg::SEED3;
  wire pd_next = pwr_reg[pfrpc_pkg::PWR_PIN_EN_BIT] ? !chip_enable_pin
               : pwr_reg[pfrpc_pkg::PWR_SW_PD_BIT];
  wire [pfrpc_pkg::KEEP_N-1:0] keep = pwr_reg[pfrpc_pkg::KEEP_LO_BIT +: pfrpc_pkg::KEEP_N];
  wire [pfrpc_pkg::DATA_W-1:0] rd_next =
    (rdaddr_reg == pfrpc_pkg::ADDR_RST_ID) ? pfrpc_pkg::CHIP_ID :
    (rdaddr_reg == pfrpc_pkg::ADDR_PWR)    ? pwr_reg :
    (rdaddr_reg == pfrpc_pkg::ADDR_INTG)   ? intg_reg :
    (rdaddr_reg == pfrpc_pkg::ADDR_FRAC)   ? frac_reg :
    (rdaddr_reg == pfrpc_pkg::ADDR_VCO)    ? vco_reg :
    (rdaddr_reg == pfrpc_pkg::ADDR_MOD)    ? mod_reg :
    (rdaddr_reg == pfrpc_pkg::ADDR_STEP)   ? step_reg : '0;

  // Power-on delay counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'h0;
    end else if (!por_done_reg) begin
      por_cnt_reg  <= por_cnt_reg + 1'h1;
      por_done_reg <= (por_cnt_reg == CNT_W'(POR_CYCLES - 1));
    end
  end

  // Subsystem registers, cleared by power-on and soft reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n || clr) begin
      pwr_reg    <= pfrpc_pkg::PWR_RST_VAL;
      intg_reg   <= pfrpc_pkg::INTG_RST_VAL;
      frac_reg   <= pfrpc_pkg::FRAC_RST_VAL;
      mod_reg    <= pfrpc_pkg::MOD_RST_VAL;
      step_reg   <= pfrpc_pkg::STEP_RST_VAL;
      rdaddr_reg <= '0;
    end else begin
      if (wr_pwr) pwr_reg <= wr_data;
      if (wr_intg) intg_reg <= wr_data;
      if (wr_frac) frac_reg <= wr_data;
      if (wr_mod) mod_reg <= wr_data;
      if (wr_step) step_reg <= wr_data;
      if (wr_r0) rdaddr_reg <= wr_data[pfrpc_pkg::RDADDR_W-1:0];
    end
  end

  // VCO registers and port mode: only the power-on path clears them
  always_ff @(posedge sys_clk) begin
    if (!rst_n || por_active) begin
      vco_reg  <= pfrpc_pkg::VCO_RST_VAL;
      mode_reg <= 1'h0;
    end else begin
      if (wr_vco) vco_reg <= wr_data;
      if (spi_mode_load) mode_reg <= spi_mode_in;
    end
  end

  // Accumulator seed reload on every new fraction
  always_ff @(posedge sys_clk) begin
    if (!rst_n || clr) acc_reg <= pfrpc_pkg::SEED0;
    else if (wr_frac) acc_reg <= seed_val;
  end

  // Power state and read data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pd_reg  <= 1'h0;
      run_reg <= 1'h1;
      on_reg  <= {pfrpc_pkg::KEEP_N{1'h1}};
      rd_reg  <= '0;
    end else begin
      pd_reg  <= pd_next;
      run_reg <= !pd_next;
      on_reg  <= pd_next ? keep : {pfrpc_pkg::KEEP_N{1'h1}};
      rd_reg  <= rd_next;
    end
  end

  assign rd_data           = rd_reg;
  assign por_done          = por_done_reg;
  assign spi_mode          = mode_reg;
  assign int_div           = intg_reg;
  assign frac_div          = frac_reg;
  assign step_count        = step_reg;
  assign mod_cfg           = mod_reg;
  assign vco_access        = vco_reg;
  assign phase_accumulator = acc_reg;
  assign powered_down      = pd_reg;
  assign clocks_run        = run_reg;
  assign block_on          = on_reg;

  a_seed_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_frac && !clr) |=> (phase_accumulator == $past(seed_val)))
    else $error("accumulator not reloaded with seed");
  a_soft_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    soft_rst |=> (int_div == pfrpc_pkg::INTG_RST_VAL && frac_div == pfrpc_pkg::FRAC_RST_VAL))
    else $error("soft reset left registers");
  a_vco_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (soft_rst && !wr_vco) |=> $stable(vco_access))
    else $error("vco register changed on soft reset");
  a_mode_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (soft_rst && !spi_mode_load) |=> $stable(spi_mode))
    else $error("port mode changed on soft reset");
  a_pin_pd: assert property (@(posedge sys_clk) disable iff (!rst_n || clr)
    (pwr_reg[pfrpc_pkg::PWR_PIN_EN_BIT] && !chip_enable_pin) |=> (powered_down && !clocks_run))
    else $error("pin low did not power down");
  a_sw_pd: assert property (@(posedge sys_clk) disable iff (!rst_n || clr)
    !pwr_reg[pfrpc_pkg::PWR_PIN_EN_BIT] |=> (powered_down == $past(pwr_reg[pfrpc_pkg::PWR_SW_PD_BIT])))
    else $error("register power-down not followed");
  a_keep_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    powered_down |-> (block_on == $past(keep)))
    else $error("keep-alive bits not applied");
  a_int_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_frac && !clr) |=> ($stable(int_div) && $stable(step_count)))
    else $error("fraction write disturbed other registers");
  a_por_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(por_done) |-> (int_div == pfrpc_pkg::INTG_RST_VAL && mod_cfg == pfrpc_pkg::MOD_RST_VAL))
    else $error("defaults missing after power-on");
  a_rd_live: assert property (@(posedge sys_clk) disable iff (!rst_n)
    powered_down |=> (rd_data == $past(rd_next)))
    else $error("readback stalled in power-down");

  // Soft reset steps: the write strobe, then subsystem defaults
  sequence s_soft_write;
    soft_rst;
  endsequence
  sequence s_sub_defaults;
    (pwr_reg == pfrpc_pkg::PWR_RST_VAL) && (mod_cfg == pfrpc_pkg::MOD_RST_VAL) &&
    (step_count == pfrpc_pkg::STEP_RST_VAL) && (phase_accumulator == pfrpc_pkg::SEED0) &&
    (rdaddr_reg == pfrpc_pkg::ADDR_RST_ID);
  endsequence
  // Pin levels while the pin is honoured
  sequence s_pin_low;
    pwr_reg[pfrpc_pkg::PWR_PIN_EN_BIT] && !chip_enable_pin;
  endsequence
  sequence s_pin_high;
    pwr_reg[pfrpc_pkg::PWR_PIN_EN_BIT] && chip_enable_pin;
  endsequence
  a_soft_defaults: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_soft_write |=> s_sub_defaults)
    else $error("soft reset left subsystem registers");
  a_pin_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pin_high |=> (!powered_down && clocks_run))
    else $error("pin high did not wake");
  a_pin_low_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pin_low |=> (block_on == $past(keep)))
    else $error("pin power-down ignored keep-alive bits");
  a_clocks_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clocks_run != powered_down))
    else $error("clocks disagree with power state");
  a_blocks_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !powered_down |-> (block_on == {pfrpc_pkg::KEEP_N{1'h1}}))
    else $error("block off while running");
  a_rd_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (powered_down && rdaddr_reg == pfrpc_pkg::ADDR_INTG) |=> (rd_data == $past(int_div)))
    else $error("readback wrong in power-down");
  a_por_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !por_done |-> (int_div == pfrpc_pkg::INTG_RST_VAL &&
                   frac_div == pfrpc_pkg::FRAC_RST_VAL))
    else $error("registers written before power-on done");
endmodule
`default_nettype wire

// File: pfrpc_host.sv
// Host model: register writes, enable pin and port mode load.
// Assumes sys_clk from the bench; changes its outputs 1 ns after rising edges.
`timescale 1ns/1ps
`default_nettype none
module pfrpc_host (
  input  wire logic                         sys_clk,
  output var  logic                         wr_strobe,
  output var  logic [pfrpc_pkg::ADDR_W-1:0] wr_addr,
  output var  logic [pfrpc_pkg::DATA_W-1:0] wr_data,
  output var  logic                         chip_enable_pin,
  output var  logic                         spi_mode_in,
  output var  logic                         spi_mode_load
);
  initial begin
    {wr_strobe, spi_mode_in, spi_mode_load} = 3'h0;
    wr_addr = 5'h00;
    wr_data = 24'h000000;
    chip_enable_pin = 1'h1;
  end
  // One-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge sys_clk) #1;
    wr_strobe = 1'h1;
    wr_addr = a;
    wr_data = d;
    @(posedge sys_clk) #1;
    wr_strobe = 1'h0;
  endtask
  task automatic pin(input logic v);
    @(posedge sys_clk) #1;
    chip_enable_pin = v;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic mode(input logic v);
    @(posedge sys_clk) #1;
    spi_mode_in = v;
    spi_mode_load = 1'h1;
    @(posedge sys_clk) #1;
    spi_mode_load = 1'h0;
  endtask
endmodule
`default_nettype wire

// File: pfrpc_ctrl_test.sv
// Testbench for the synthesizer control register bank.
// Assumes pfrpc_pkg, pfrpc_ctrl and pfrpc_host are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pfrpc_ctrl_test;
  logic        sys_clk;
  logic        rst_n;
  wire logic   wr_strobe, chip_enable_pin, spi_mode_in, spi_mode_load;
  wire logic   por_done, spi_mode, powered_down, clocks_run;
  wire logic [4:0]  wr_addr;
  wire logic [5:0]  block_on;
  wire logic [23:0] wr_data, rd_data, int_div, frac_div, step_count, mod_cfg, vco_access, acc;
  int          mismatches = 0;
  int          comparisons = 0;
  logic [23:0] seeds [4] = '{pfrpc_pkg::SEED0, pfrpc_pkg::SEED1, pfrpc_pkg::SEED2,
                             pfrpc_pkg::SEED3};
  pfrpc_host host_u (.sys_clk(sys_clk), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .chip_enable_pin(chip_enable_pin), .spi_mode_in(spi_mode_in),
    .spi_mode_load(spi_mode_load));
  pfrpc_ctrl #(.POR_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .chip_enable_pin(chip_enable_pin), .spi_mode_in(spi_mode_in),
    .spi_mode_load(spi_mode_load), .rd_data(rd_data), .por_done(por_done),
    .spi_mode(spi_mode), .int_div(int_div), .frac_div(frac_div), .step_count(step_count),
    .mod_cfg(mod_cfg), .vco_access(vco_access), .phase_accumulator(acc),
    .powered_down(powered_down), .clocks_run(clocks_run), .block_on(block_on));
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk) #1;
  endtask
  // Select then read back one register
  task automatic rd(input logic [4:0] a, input logic [23:0] exp);
    host_u.wr(pfrpc_pkg::ADDR_RST_ID, {19'h0, a});
    tick();
    chk24(rd_data, exp);
  endtask
  initial begin
    #50000;
    mismatches++;
    stop_test();
  end
  initial begin
    rst_n = 1'h0;
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'h1;
    host_u.wr(pfrpc_pkg::ADDR_FRAC, 24'h123456);
    for (int i = 0; i < 100 && por_done !== 1'h1; i++) tick();
    chk1(por_done, 1'h1);
    chk24(frac_div, pfrpc_pkg::FRAC_RST_VAL);
    host_u.wr(pfrpc_pkg::ADDR_RST_ID, 24'h000020);
    chk24(int_div, pfrpc_pkg::INTG_RST_VAL);
    chk24(mod_cfg, pfrpc_pkg::MOD_RST_VAL);
    rd(pfrpc_pkg::ADDR_PWR, pfrpc_pkg::PWR_RST_VAL);
    $display("test reset done");
    host_u.wr(pfrpc_pkg::ADDR_INTG, 24'h00002D);
    host_u.wr(pfrpc_pkg::ADDR_STEP, 24'h000C00);
    host_u.wr(pfrpc_pkg::ADDR_FRAC, 24'h938000);
    host_u.wr(pfrpc_pkg::ADDR_MOD, 24'h000002);
    host_u.wr(pfrpc_pkg::ADDR_FRAC, 24'h93EAAB);
    chk24(frac_div, 24'h93EAAB);
    chk24(int_div, 24'h00002D);
    chk24(step_count, 24'h000C00);
    chk24(acc, pfrpc_pkg::SEED2);
    for (int k = 0; k < 4; k++) begin
      host_u.wr(pfrpc_pkg::ADDR_MOD, 24'(k));
      host_u.wr(pfrpc_pkg::ADDR_FRAC, 24'(k + 1));
      chk24(acc, seeds[k]);
    end
    $display("test channel done");
    host_u.mode(1'h1);
    host_u.wr(pfrpc_pkg::ADDR_VCO, 24'h123456);
    host_u.wr(pfrpc_pkg::ADDR_RST_ID, 24'h000020);
    chk24(int_div, pfrpc_pkg::INTG_RST_VAL);
    chk1(spi_mode, 1'h1);
    chk24(vco_access, 24'h123456);
    $display("test soft reset done");
    host_u.wr(pfrpc_pkg::ADDR_VCO, 24'h000000);
    host_u.pin(1'h0);
    chk1(powered_down, 1'h1);
    chk1(clocks_run, 1'h0);
    rd(pfrpc_pkg::ADDR_INTG, pfrpc_pkg::INTG_RST_VAL);
    rd(pfrpc_pkg::ADDR_RST_ID, pfrpc_pkg::CHIP_ID);
    rd(5'h02, 24'h000000);
    host_u.pin(1'h1);
    chk1(powered_down, 1'h0);
    host_u.wr(pfrpc_pkg::ADDR_PWR, 24'h0000A6);
    tick();
    chk1(powered_down, 1'h1);
    chk24({18'h0, block_on}, 24'h000029);
    host_u.wr(pfrpc_pkg::ADDR_PWR, 24'h000000);
    tick();
    chk1(powered_down, 1'h0);
    chk24({18'h0, block_on}, 24'h00003F);
    $display("test power done");
    // Power cycle in mid-run clears the VCO side as well
    host_u.wr(pfrpc_pkg::ADDR_VCO, 24'h00ABCD);
    tick();
    rst_n = 1'h0;
    repeat (8) tick();
    rst_n = 1'h1;
    for (int i = 0; i < 100 && por_done !== 1'h1; i++) tick();
    chk1(por_done, 1'h1);
    chk24(vco_access, pfrpc_pkg::VCO_RST_VAL);
    chk1(spi_mode, 1'h0);
    rd(pfrpc_pkg::ADDR_PWR, pfrpc_pkg::PWR_RST_VAL);
    $display("test power cycle done");
    stop_test();
  end
endmodule
`default_nettype wire
